// file: core/asrr_readout.v
// Summary of operation
// - data changes on the falling serial clock edge, the host samples on the rising edge.
// - after a result is read, active-low ready is driven high.
// - in continuous read mode each word goes to at most one read.
// - hold flag clear: pin shows ready after the last inactive edge.
// - hold flag set: pin keeps the lsb until chip select goes high.
// - new word while ready is low, outside a read, pulses ready high 6, 25 or 50 us.
`timescale 1ns/100ps
`include "asrr_consts.vh"

module asrr_readout #(
    parameter DATA_W = `ASRR_DATA_W
) (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // converter core side, same clock
    input wire [DATA_W-1:0] conv_data_i,
    input wire conv_valid_i,
    input wire [1:0] conv_mode_i,
    input wire [1:0] power_mode_i,
    input wire cs_hold_i,
    // serial pins, asynchronous
    input wire sclk_i,
    input wire cs_n_i,
    output wire dout_rdy_o,
    output wire dout_rdy_oe_o,
    // status
    output wire rdy_n_o,
    output wire reading_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg sclk_m_r;
    reg sclk_s_r;
    reg sclk_d_r;
    reg cs_m_r;
    reg cs_s_r;

    // first stages feed only the second stages
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            sclk_m_r <= 1'b1;
            sclk_s_r <= 1'b1;
            sclk_d_r <= 1'b1;
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
        end
        else
        begin
            sclk_m_r <= sclk_i;
            sclk_s_r <= sclk_m_r;
            sclk_d_r <= sclk_s_r;
            cs_m_r <= cs_n_i;
            cs_s_r <= cs_m_r;
        end
    end

    wire sclk_fall = sclk_d_r & ~sclk_s_r;
    wire sclk_rise = ~sclk_d_r & sclk_s_r;
    wire cs_active = ~cs_s_r;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_HOLD = 2'd2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [DATA_W-1:0] word_r;
    reg [DATA_W-1:0] word_nxt;
    reg [DATA_W-1:0] stage_r;
    reg [DATA_W-1:0] stage_nxt;
    reg pend_r;
    reg pend_nxt;
    reg fresh_r;
    reg fresh_nxt;
    reg [5:0] bits_r;
    reg [5:0] bits_nxt;
    reg rdy_n_r;
    reg rdy_n_nxt;
    reg [`ASRR_CNT_W-1:0] pulse_r;
    reg [`ASRR_CNT_W-1:0] pulse_nxt;
    reg dout_r;
    reg dout_nxt;
    reg oe_r;
    reg oe_nxt;
    reg [`ASRR_CNT_W-1:0] pulse_len;
    reg new_word;
    reg [DATA_W-1:0] new_data;
    reg read_done;
    reg reading_r;

    // ready pulse length per power mode
    always @*
    begin
        case (power_mode_i)
            `ASRR_PWR_FULL:
                pulse_len = `ASRR_RDY_PULSE_FULL_CYC;
            `ASRR_PWR_MID:
                pulse_len = `ASRR_RDY_PULSE_MID_CYC;
            default:
                pulse_len = `ASRR_RDY_PULSE_LOW_CYC;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always @*
    begin
        state_nxt = state_r;
        word_nxt = word_r;
        stage_nxt = stage_r;
        pend_nxt = pend_r;
        fresh_nxt = fresh_r;
        bits_nxt = bits_r;
        rdy_n_nxt = rdy_n_r;
        pulse_nxt = pulse_r;
        dout_nxt = dout_r;
        new_word = 1'b0;
        new_data = conv_data_i;
        read_done = 1'b0;

        // a word landing mid-read is parked so the shift stays intact
        if (state_r == ST_SHIFT)
        begin
            if (conv_valid_i)
            begin
                stage_nxt = conv_data_i;
                pend_nxt = 1'b1;
            end
        end
        else if (conv_valid_i)
        begin
            // a direct word supersedes an older parked one
            new_word = 1'b1;
            pend_nxt = 1'b0;
        end
        else if (pend_r)
        begin
            new_word = 1'b1;
            new_data = stage_r;
            pend_nxt = 1'b0;
        end

        case (state_r)
            ST_IDLE:
            begin
                // continuous read gives each word to one read only
                if (cs_active && sclk_fall && !new_word &&
                    (conv_mode_i != `ASRR_CONV_CONTREAD || fresh_r))
                begin
                    state_nxt = ST_SHIFT;
                    dout_nxt = word_r[DATA_W-1];
                    bits_nxt = 6'd1;
                end
            end
            ST_SHIFT:
            begin
                if (!cs_active)
                    state_nxt = ST_IDLE;
                else if (sclk_fall && bits_r < DATA_W)
                begin
                    dout_nxt = word_r[DATA_W-1-bits_r];
                    bits_nxt = bits_r + 6'd1;
                end
                else if (sclk_rise && bits_r == DATA_W)
                begin
                    // read complete: ready goes high, word is used up
                    rdy_n_nxt = 1'b1;
                    read_done = 1'b1;
                    pulse_nxt = {`ASRR_CNT_W{1'b0}};
                    fresh_nxt = 1'b0;
                    if (cs_hold_i)
                        state_nxt = ST_HOLD;
                    else
                        state_nxt = ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                // lsb stays put until chip select rises
                if (!cs_active)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase

        // new result: pulse ready high first if it was already low
        if (new_word)
        begin
            word_nxt = new_data;
            fresh_nxt = 1'b1;
            if (!rdy_n_r)
            begin
                rdy_n_nxt = 1'b1;
                pulse_nxt = pulse_len;
            end
            else
                rdy_n_nxt = 1'b0;
        end
        // a finished read cancels a running pulse, ready must stay high
        else if (pulse_r != {`ASRR_CNT_W{1'b0}} && !read_done)
        begin
            pulse_nxt = pulse_r - 1'b1;
            if (pulse_r == 1)
                rdy_n_nxt = 1'b0;
        end

        // pin shows ready unless shifting or holding the lsb
        if (state_nxt == ST_IDLE)
            dout_nxt = rdy_n_nxt;
        oe_nxt = cs_active;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_r <= ST_IDLE;
            word_r <= `ASRR_DATA_RST;
            stage_r <= `ASRR_DATA_RST;
            pend_r <= 1'b0;
            fresh_r <= 1'b0;
            bits_r <= 6'd0;
            rdy_n_r <= 1'b1;
            pulse_r <= {`ASRR_CNT_W{1'b0}};
            dout_r <= 1'b1;
            oe_r <= 1'b0;
            reading_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            word_r <= word_nxt;
            stage_r <= stage_nxt;
            pend_r <= pend_nxt;
            fresh_r <= fresh_nxt;
            bits_r <= bits_nxt;
            rdy_n_r <= rdy_n_nxt;
            pulse_r <= pulse_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            reading_r <= (state_nxt == ST_SHIFT);
        end
    end

    // the host keeps its own gap between operations
    // a word landing mid-read is parked, so one read never mixes two words
    assign dout_rdy_o = dout_r;
    assign dout_rdy_oe_o = oe_r;
    assign rdy_n_o = rdy_n_r;
    assign reading_o = reading_r;

endmodule // asrr_readout

// file: core/asrr_consts.vh
`ifndef ASRR_CONSTS_VH
`define ASRR_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define ASRR_CLK_HZ 40000000
// ready high pulse when a fresh word replaces an unread one, in us
`define ASRR_RDY_PULSE_FULL_US 6
`define ASRR_RDY_PULSE_MID_US 25
`define ASRR_RDY_PULSE_LOW_US 50
// cycles = us times clock MHz, a typical time so it is taken as is;
// sized to the pulse counter so no bits are dropped on assignment
`define ASRR_RDY_PULSE_FULL_CYC 12'h0F0
`define ASRR_RDY_PULSE_MID_CYC 12'h3E8
`define ASRR_RDY_PULSE_LOW_CYC 12'h7D0
`define ASRR_CNT_W 12

// ----------------------------------------------------------------
// mode encodings
// ----------------------------------------------------------------
`define ASRR_CONV_CONT 2'b00
`define ASRR_CONV_SINGLE 2'b01
`define ASRR_CONV_CONTREAD 2'b10
`define ASRR_PWR_LOW 2'b00
`define ASRR_PWR_MID 2'b01
`define ASRR_PWR_FULL 2'b10

// ----------------------------------------------------------------
// word and reset values
// ----------------------------------------------------------------
`define ASRR_DATA_W 24
`define ASRR_DATA_RST 24'h00_0000

`endif

// file: bench/asrr_readout_sva.sv
`timescale 1ns/100ps
// ------------------------------------------------
// pin and ready checks
// ------------------------------------------------
module asrr_readout_sva (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // core side
    input wire conv_valid_i,
    input wire [1:0] conv_mode_i,
    input wire cs_hold_i,
    // pins and status
    input wire sclk_i,
    input wire cs_n_i,
    input wire dout_rdy_o,
    input wire dout_rdy_oe_o,
    input wire rdy_n_o,
    input wire reading_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // data bits move only while the serial clock is low
    shift_edge_a:
        assert property (reading_o && $changed(dout_rdy_o) |-> !sclk_i)
        else $error("pin moved in sclk high phase");
    // a read completed while chip select stays low leaves ready high
    rdy_clear_a:
        assert property (!cs_n_i && $fell(reading_o) |-> rdy_n_o)
        else $error("ready still low after read");
    single_read_a:
        assert property (conv_mode_i == 2'h2 && rdy_n_o && !conv_valid_i
            && !reading_o |=> !reading_o) else $error("word read twice");
    rdy_pin_a:
        assert property (!cs_hold_i && !cs_n_i && $fell(reading_o)
            |-> dout_rdy_o) else $error("pin not back to ready");
    hold_lsb_a:
        assert property (cs_hold_i && $fell(reading_o)
            |=> ($stable(dout_rdy_o) || cs_n_i) [*4])
        else $error("lsb not held");
    rdy_pulse_a:
        assert property (!rdy_n_o && conv_valid_i && !reading_o
            |=> rdy_n_o [*8]) else $error("no ready pulse");
    oe_on_a:
        assert property ((!cs_n_i) [*5] |-> dout_rdy_oe_o)
        else $error("pin not driven");
    oe_off_a:
        assert property (cs_n_i [*5] |-> !dout_rdy_oe_o)
        else $error("pin not released");
    // main scenarios seen
    cov_hold: cover property (cs_hold_i && $fell(reading_o));
    cov_pulse: cover property (!rdy_n_o && conv_valid_i);
    cov_cread: cover property (conv_mode_i == 2'h2 && $fell(reading_o));
endmodule // asrr_readout_sva

// file: bench/asrr_host.sv
`timescale 1ns/100ps
// ------------------------------------------------
// serial host model
// ------------------------------------------------
module asrr_host (
    // clock and pin
    input wire clk_i,
    input wire pin_i,
    // serial outputs
    output reg sclk_o,
    output reg cs_n_o
);
    // sclk idles high and stands still outside a frame
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
    end
    // one 24-bit read; cs stays low so the bench can look at the pin
    task xfer(output [23:0] w);
        integer i;
        begin
            repeat (24) @(negedge clk_i);
            cs_n_o = 1'b0;
            repeat (8) @(negedge clk_i);
            for (i = 23; i >= 0; i = i - 1)
            begin
                sclk_o = 1'b0;
                repeat (8) @(negedge clk_i);
                sclk_o = 1'b1;
                w[i] = pin_i; // settled well after the falling edge
                repeat (8) @(negedge clk_i);
            end
        end
    endtask
    // close the frame
    task cs_up;
        cs_n_o = 1'b1;
    endtask
endmodule // asrr_host

// file: bench/test_asrr_readout.sv
`timescale 1ns/100ps
`include "asrr_consts.vh"
// ------------------------------------------------
// readout testbench
// ------------------------------------------------
module test_asrr_readout;
    reg clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [23:0] conv_data_i = 24'h00_0000;
    reg conv_valid_i = 1'b0;
    reg [1:0] conv_mode_i = 2'h0;
    reg [1:0] power_mode_i = 2'h2;
    reg cs_hold_i = 1'b0;
    reg last_r = 1'b0;
    wire sclk_w, cs_n_w, dout_rdy_o, dout_rdy_oe_o, rdy_n_o, reading_o;
    wire pin_w = dout_rdy_oe_o ? dout_rdy_o : ~last_r;
    integer bad_count = 0;
    integer cmp_count = 0;
    integer n;
    reg [23:0] w;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    // a released pin shows the inverse level, never a stale copy
    always @(posedge clk_i) if (dout_rdy_oe_o) last_r <= dout_rdy_o;
    asrr_readout i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
        .conv_mode_i(conv_mode_i), .power_mode_i(power_mode_i),
        .cs_hold_i(cs_hold_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w),
        .dout_rdy_o(dout_rdy_o), .dout_rdy_oe_o(dout_rdy_oe_o),
        .rdy_n_o(rdy_n_o), .reading_o(reading_o));
    asrr_host i_host (.clk_i(clk_i), .pin_i(pin_w), .sclk_o(sclk_w),
        .cs_n_o(cs_n_w));
    // compare and count
    task chk(input string nm, input [23:0] e, input [23:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e)
            begin
                bad_count = bad_count + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // one word from the converter core
    task push(input [23:0] d);
        begin
            conv_data_i = d;
            conv_valid_i = 1'b1;
            @(negedge clk_i);
            conv_valid_i = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask
    // lsb of the word is 0 so a held lsb cannot pass as ready high
    task t_plain;
        begin
            push(24'hC3_96A4);
            chk("rdy", 24'h0, rdy_n_o);
            i_host.xfer(w);
            chk("word", 24'hC3_96A4, w);
            repeat (6) @(negedge clk_i);
            chk("pin", 24'h1, pin_w);
            chk("oe", 24'h1, dout_rdy_oe_o);
            chk("rdy", 24'h1, rdy_n_o);
            chk("reading", 24'h0, reading_o);
            i_host.cs_up;
            repeat (6) @(negedge clk_i);
            chk("oe", 24'h0, dout_rdy_oe_o);
            // re-read of the held word in single conversion mode
            conv_mode_i = 2'h1;
            i_host.xfer(w);
            chk("again", 24'hC3_96A4, w);
            i_host.cs_up;
            conv_mode_i = 2'h0;
        end
    endtask
    task t_hold;
        begin
            cs_hold_i = 1'b1;
            push(24'h5A_A55A);
            i_host.xfer(w);
            chk("word", 24'h5A_A55A, w);
            repeat (6) @(negedge clk_i);
            chk("lsb", 24'h0, pin_w);
            i_host.cs_up;
            repeat (6) @(negedge clk_i);
            chk("oe", 24'h0, dout_rdy_oe_o);
            cs_hold_i = 1'b0;
        end
    endtask
    task t_cread;
        begin
            conv_mode_i = 2'h2;
            push(24'h3C_0F1E);
            i_host.xfer(w);
            chk("word", 24'h3C_0F1E, w);
            i_host.cs_up;
            i_host.xfer(w);
            chk("once", 24'hFF_FFFF, w);
            i_host.cs_up;
            conv_mode_i = 2'h0;
        end
    endtask
    // fresh word over an unread one, in every power mode
    task t_pulse;
        integer p;
        begin
            for (p = 0; p < 3; p = p + 1)
            begin
                power_mode_i = p[1:0];
                push(24'h12_3456);
                conv_data_i = 24'h65_4321;
                conv_valid_i = 1'b1;
                @(negedge clk_i);
                conv_valid_i = 1'b0;
                repeat (3) if (rdy_n_o !== 1'b1) @(negedge clk_i);
                n = 0;
                while (rdy_n_o === 1'b1 && n < 3000)
                begin
                    n = n + 1;
                    @(negedge clk_i);
                end
                chk("pulse", p == 2 ? 24'(`ASRR_RDY_PULSE_FULL_CYC) : p == 1
                    ? 24'(`ASRR_RDY_PULSE_MID_CYC)
                    : 24'(`ASRR_RDY_PULSE_LOW_CYC), n[23:0]);
                i_host.xfer(w);
                chk("new", 24'h65_4321, w);
                i_host.cs_up;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_plain;
        t_hold;
        t_cread;
        t_pulse;
        give_verdict;
    end
    // watchdog, several times the expected run of about 6600 cycles
    initial
    begin
        #(25 * 40000);
        bad_count = bad_count + 1;
        give_verdict;
    end
endmodule // test_asrr_readout
bind asrr_readout asrr_readout_sva i_sva (.clk_i(clk_i),
    .resetn_i(resetn_i), .conv_valid_i(conv_valid_i),
    .conv_mode_i(conv_mode_i), .cs_hold_i(cs_hold_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .dout_rdy_o(dout_rdy_o),
    .dout_rdy_oe_o(dout_rdy_oe_o), .rdy_n_o(rdy_n_o),
    .reading_o(reading_o));
